// [verilog/lpt_top.sv]
`timescale 1ns/1ps
`default_nettype none
module lpt_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [lpt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lpt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [lpt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic adc_clk_tick,
  output logic vis_adc_tick,
  output logic ir_adc_tick,
  input wire logic [lpt_pkg::GAIN_W-1:0] ir_gain_in,
  input wire logic ir_range_in,
  input wire logic [2:0] ir_recovery_in,
  input wire logic [2:0] vis_recovery_in,
  output logic [lpt_pkg::GAIN_W-1:0] visible_integration_gain,
  output logic visible_signal_range,
  output logic [lpt_pkg::GAIN_W-1:0] ir_gain_eff,
  output logic ir_range_eff,
  output logic [2:0] ir_recovery_eff,
  output logic [lpt_pkg::SAMPLE_W-1:0] ambient_hysteresis,
  output logic [lpt_pkg::SAMPLE_W-1:0] proximity_hysteresis,
  input wire logic amb_sample_valid,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] amb_sample,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] ambient_lower_threshold,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] ambient_upper_threshold,
  input wire logic [2:0] prox_sample_valid,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] prox1_sample,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] prox2_sample,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] prox3_sample,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] proximity_threshold_one,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] proximity_threshold_two,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] proximity_threshold_three,
  output logic amb_above_status,
  output logic amb_below_status,
  output logic [2:0] prox_status,
  output logic irq
);
  import lpt_pkg::*;

  logic [GAIN_W-1:0] vis_gain_ff;
  logic vis_sig_range_ff;
  logic [7:0] amb_hyst_code_ff;
  logic [7:0] prox_hyst_code_ff;
  logic [HIST_W-1:0] prox_persist_ff;
  logic [HIST_W-1:0] amb_persist_ff;
  logic legacy_seq_ff;
  logic [NUM_CHAN-1:0] irq_status_ff;
  logic [NUM_CHAN-1:0] irq_mask_ff;
  logic irq_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [GAIN_W-1:0] ir_gain_ff;
  logic ir_range_ff;
  logic [2:0] ir_recovery_ff;
  logic [SAMPLE_W-1:0] amb_hyst_val_ff;
  logic [SAMPLE_W-1:0] prox_hyst_val_ff;
  logic [DIV_W-1:0] vis_div_ff;
  logic [DIV_W-1:0] ir_div_ff;
  logic vis_tick_ff;
  logic ir_tick_ff;

  logic [NUM_CHAN-1:0] chan_valid;
  logic [NUM_CHAN-1:0] chan_set;
  logic [NUM_CHAN-1:0] chan_clr;
  logic [NUM_CHAN-1:0] chan_status;
  logic [NUM_CHAN-1:0] chan_change;
  logic [SAMPLE_W-1:0] chan_sample [NUM_CHAN];
  logic [SAMPLE_W-1:0] chan_th [NUM_CHAN];
  logic [SAMPLE_W-1:0] chan_hyst [NUM_CHAN];
  logic [HIST_W-1:0] chan_mask [NUM_CHAN];
  logic [NUM_CHAN-1:0] nxt_irq_status;
  logic [DATA_W-1:0] nxt_rdata;

  // Register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      vis_gain_ff <= RST_VIS_GAIN;
      vis_sig_range_ff <= RST_VIS_SIG_RANGE;
      amb_hyst_code_ff <= RST_AMB_HYST;
      prox_hyst_code_ff <= RST_PROX_HYST;
      prox_persist_ff <= RST_PROX_PERSIST;
      amb_persist_ff <= RST_AMB_PERSIST;
      legacy_seq_ff <= RST_LEGACY_SEQ;
      irq_mask_ff <= RST_IRQ_MASK;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_VIS_GAIN) begin
        // three-bit field keeps low bits 2:0 of the write data, upper bits dropped
        vis_gain_ff <= reg_wdata[GAIN_W-1:0];
      end else if (reg_addr == ADDR_VIS_MISC) begin
        vis_sig_range_ff <= reg_wdata[VIS_SIG_RANGE_BIT];
      end else if (reg_addr == ADDR_AMB_HYST) begin
        amb_hyst_code_ff <= reg_wdata;
      end else if (reg_addr == ADDR_PROX_HYST) begin
        prox_hyst_code_ff <= reg_wdata;
      end else if (reg_addr == ADDR_PROX_PERSIST) begin
        prox_persist_ff <= reg_wdata;
      end else if (reg_addr == ADDR_AMB_PERSIST) begin
        amb_persist_ff <= reg_wdata;
      end else if (reg_addr == ADDR_CTRL) begin
        legacy_seq_ff <= reg_wdata[LEGACY_SEQ_BIT];
      end else if (reg_addr == ADDR_IRQ_MASK) begin
        irq_mask_ff <= reg_wdata[NUM_CHAN-1:0];
      end
    end
  end

  // Read mux, unmapped reads give zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_addr == ADDR_VIS_GAIN) begin
      nxt_rdata = {5'h00, vis_gain_ff};
    end else if (reg_addr == ADDR_VIS_MISC) begin
      nxt_rdata = {2'h0, vis_sig_range_ff, 5'h00};
    end else if (reg_addr == ADDR_AMB_HYST) begin
      nxt_rdata = amb_hyst_code_ff;
    end else if (reg_addr == ADDR_PROX_HYST) begin
      nxt_rdata = prox_hyst_code_ff;
    end else if (reg_addr == ADDR_PROX_PERSIST) begin
      nxt_rdata = prox_persist_ff;
    end else if (reg_addr == ADDR_AMB_PERSIST) begin
      nxt_rdata = amb_persist_ff;
    end else if (reg_addr == ADDR_CTRL) begin
      nxt_rdata = {7'h00, legacy_seq_ff};
    end else if (reg_addr == ADDR_IRQ_STATUS) begin
      nxt_rdata = {3'h0, irq_status_ff};
    end else if (reg_addr == ADDR_IRQ_MASK) begin
      nxt_rdata = {3'h0, irq_mask_ff};
    end else if (reg_addr == ADDR_THR_STATUS) begin
      nxt_rdata = {3'h0, chan_status};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ir_gain_ff <= RST_VIS_GAIN;
      ir_range_ff <= RST_VIS_SIG_RANGE;
      ir_recovery_ff <= 3'h0;
    end else if (legacy_seq_ff) begin
      ir_gain_ff <= vis_gain_ff;
      ir_range_ff <= vis_sig_range_ff;
      ir_recovery_ff <= vis_recovery_in;
    end else begin
      ir_gain_ff <= ir_gain_in;
      ir_range_ff <= ir_range_in;
      ir_recovery_ff <= ir_recovery_in;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      vis_div_ff <= 7'h00;
      vis_tick_ff <= 1'b0;
    end else begin
      vis_tick_ff <= 1'b0;
      if (adc_clk_tick) begin
        if (vis_div_ff >= lpt_div_limit(vis_gain_ff)) begin
          vis_div_ff <= 7'h00;
          vis_tick_ff <= 1'b1;
        end else begin
          vis_div_ff <= vis_div_ff + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ir_div_ff <= 7'h00;
      ir_tick_ff <= 1'b0;
    end else begin
      ir_tick_ff <= 1'b0;
      if (adc_clk_tick) begin
        if (ir_div_ff >= lpt_div_limit(ir_gain_ff)) begin
          ir_div_ff <= 7'h00;
          ir_tick_ff <= 1'b1;
        end else begin
          ir_div_ff <= ir_div_ff + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      amb_hyst_val_ff <= lpt_expand_hyst(RST_AMB_HYST);
      prox_hyst_val_ff <= lpt_expand_hyst(RST_PROX_HYST);
    end else begin
      amb_hyst_val_ff <= lpt_expand_hyst(amb_hyst_code_ff);
      prox_hyst_val_ff <= lpt_expand_hyst(prox_hyst_code_ff);
    end
  end

  always_comb begin
    chan_valid = {prox_sample_valid, amb_sample_valid, amb_sample_valid};
    chan_sample[CHAN_AMB_ABOVE] = amb_sample;
    chan_sample[CHAN_AMB_BELOW] = amb_sample;
    chan_th[CHAN_AMB_ABOVE] = ambient_upper_threshold;
    chan_th[CHAN_AMB_BELOW] = ambient_lower_threshold;
    chan_hyst[CHAN_AMB_ABOVE] = amb_hyst_val_ff;
    chan_hyst[CHAN_AMB_BELOW] = amb_hyst_val_ff;
    chan_mask[CHAN_AMB_ABOVE] = amb_persist_ff;
    chan_mask[CHAN_AMB_BELOW] = amb_persist_ff;
    chan_sample[CHAN_PROX_FIRST] = prox1_sample;
    chan_sample[CHAN_PROX_FIRST + 1] = prox2_sample;
    chan_sample[CHAN_PROX_FIRST + 2] = prox3_sample;
    chan_th[CHAN_PROX_FIRST] = proximity_threshold_one;
    chan_th[CHAN_PROX_FIRST + 1] = proximity_threshold_two;
    chan_th[CHAN_PROX_FIRST + 2] = proximity_threshold_three;
    for (int i = CHAN_PROX_FIRST; i < NUM_CHAN; i++) begin
      chan_hyst[i] = prox_hyst_val_ff;
      chan_mask[i] = prox_persist_ff;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
      logic [SAMPLE_W:0] samp_plus;
      logic [SAMPLE_W:0] th_plus;
      logic [SAMPLE_W:0] samp_ext;
      logic [SAMPLE_W:0] th_ext;
      assign samp_ext = {1'b0, chan_sample[gc]};
      assign th_ext = {1'b0, chan_th[gc]};
      assign samp_plus = samp_ext + {1'b0, chan_hyst[gc]};
      assign th_plus = th_ext + {1'b0, chan_hyst[gc]};
      if (gc == CHAN_AMB_BELOW) begin : g_below
        // Below lower threshold less hysteresis
        assign chan_set[gc] = samp_plus < th_ext;
        assign chan_clr[gc] = samp_ext > th_plus;
      end else begin : g_above
        // Above threshold plus hysteresis
        assign chan_set[gc] = samp_ext > th_plus;
        assign chan_clr[gc] = samp_plus < th_ext;
      end
      lpt_persist #(
        .HIST_W(HIST_W)
      ) u_persist (
        .clk(clk),
        .reset(reset),
        .sample_valid(chan_valid[gc]),
        .set_cond(chan_set[gc]),
        .clr_cond(chan_clr[gc]),
        .persist_mask(chan_mask[gc]),
        .status(chan_status[gc]),
        .change(chan_change[gc])
      );
    end
  endgenerate

  // Sticky events, set beats write-one clear
  always_comb begin
    nxt_irq_status = irq_status_ff;
    if (reg_wr && (reg_addr == ADDR_IRQ_STATUS)) begin
      nxt_irq_status = irq_status_ff & ~reg_wdata[NUM_CHAN-1:0];
    end
    nxt_irq_status = nxt_irq_status | chan_change;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_status_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  assign reg_rdata = rdata_ff;
  assign vis_adc_tick = vis_tick_ff;
  assign ir_adc_tick = ir_tick_ff;
  assign visible_integration_gain = vis_gain_ff;
  assign visible_signal_range = vis_sig_range_ff;
  assign ir_gain_eff = ir_gain_ff;
  assign ir_range_eff = ir_range_ff;
  assign ir_recovery_eff = ir_recovery_ff;
  assign ambient_hysteresis = amb_hyst_val_ff;
  assign proximity_hysteresis = prox_hyst_val_ff;
  assign amb_above_status = chan_status[CHAN_AMB_ABOVE];
  assign amb_below_status = chan_status[CHAN_AMB_BELOW];
  assign prox_status = chan_status[NUM_CHAN-1:CHAN_PROX_FIRST];
  assign irq = irq_ff;
endmodule : lpt_top
`default_nettype wire

// [verilog/lpt_pkg.sv]
// Overview of operation
// - Visible integration divides ADC clock by 2^gain
// - Gain code tops out at 7, x128
// - Legacy sequencer: visible settings drive infrared too
// - Misc bit 5 selects high signal range
// - Ambient hysteresis widens both ambient thresholds
// - Proximity hysteresis widens all three thresholds
// - 8-bit hysteresis code expands to 16 bits
// - Proximity mask sets consecutive samples needed
// - Ambient mask sets consecutive samples needed
`default_nettype none
package lpt_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned GAIN_W = 3;
  localparam int unsigned DIV_W = 7;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned HIST_W = 8;
  localparam int unsigned NUM_CHAN = 5;

  localparam logic [7:0] ADDR_VIS_GAIN = 8'h11;
  localparam logic [7:0] ADDR_VIS_MISC = 8'h12;
  localparam logic [7:0] ADDR_AMB_HYST = 8'h16;
  localparam logic [7:0] ADDR_PROX_HYST = 8'h17;
  localparam logic [7:0] ADDR_PROX_PERSIST = 8'h18;
  localparam logic [7:0] ADDR_AMB_PERSIST = 8'h19;
  localparam logic [7:0] ADDR_CTRL = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h21;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h22;
  localparam logic [7:0] ADDR_THR_STATUS = 8'h23;

  localparam logic [2:0] RST_VIS_GAIN = 3'h0;
  localparam logic RST_VIS_SIG_RANGE = 1'b0;
  localparam logic [7:0] RST_AMB_HYST = 8'h48;
  localparam logic [7:0] RST_PROX_HYST = 8'h48;
  localparam logic [7:0] RST_PROX_PERSIST = 8'h03;
  localparam logic [7:0] RST_AMB_PERSIST = 8'h03;
  localparam logic RST_LEGACY_SEQ = 1'b0;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;

  localparam int unsigned VIS_SIG_RANGE_BIT = 5;
  localparam int unsigned LEGACY_SEQ_BIT = 0;
  localparam int unsigned CODE_EXP_MSB = 7;
  localparam int unsigned CODE_EXP_LSB = 4;
  localparam int unsigned CODE_MANT_MSB = 3;
  localparam int unsigned CODE_MANT_LSB = 0;

  localparam int unsigned CHAN_AMB_ABOVE = 0;
  localparam int unsigned CHAN_AMB_BELOW = 1;
  localparam int unsigned CHAN_PROX_FIRST = 2;

  function automatic logic [15:0] lpt_expand_hyst(input logic [7:0] code);
    logic [35:0] wide;
    wide = 36'h0;
    if (code == 8'h00) begin
      lpt_expand_hyst = 16'h0000;
    end else begin
      wide = {31'h0, 1'b1, code[CODE_MANT_MSB:CODE_MANT_LSB]} << code[CODE_EXP_MSB:CODE_EXP_LSB];
      lpt_expand_hyst = wide[19:4];
    end
  endfunction : lpt_expand_hyst

  function automatic logic [6:0] lpt_div_limit(input logic [2:0] gain);
    logic [7:0] pow;
    pow = 8'h01 << gain;
    lpt_div_limit = pow[6:0] - 7'h01;
  endfunction : lpt_div_limit
endpackage : lpt_pkg
`default_nettype wire

// [verilog/lpt_persist.sv]
`timescale 1ns/1ps
`default_nettype none
module lpt_persist #(
  parameter int unsigned HIST_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic sample_valid,
  input wire logic set_cond,
  input wire logic clr_cond,
  input wire logic [HIST_W-1:0] persist_mask,
  output logic status,
  output logic change
);
  logic [HIST_W-1:0] set_hist_ff;
  logic [HIST_W-1:0] clr_hist_ff;
  logic [HIST_W-1:0] nxt_set_hist;
  logic [HIST_W-1:0] nxt_clr_hist;
  logic [HIST_W-1:0] eff_mask;
  logic status_ff;
  logic change_ff;

  assign nxt_set_hist = {set_hist_ff[HIST_W-2:0], set_cond};
  assign nxt_clr_hist = {clr_hist_ff[HIST_W-2:0], clr_cond};
  // Newest sample always counts, so a zero mask cannot toggle freely
  assign eff_mask = persist_mask | {{(HIST_W-1){1'b0}}, 1'b1};

  always_ff @(posedge clk) begin
    if (reset) begin
      set_hist_ff <= '0;
      clr_hist_ff <= '0;
    end else if (sample_valid) begin
      set_hist_ff <= nxt_set_hist;
      clr_hist_ff <= nxt_clr_hist;
    end
  end

  // change only when all masked bits set
  always_ff @(posedge clk) begin
    if (reset) begin
      status_ff <= 1'b0;
      change_ff <= 1'b0;
    end else begin
      change_ff <= 1'b0;
      if (sample_valid) begin
        if (!status_ff && ((nxt_set_hist & eff_mask) == eff_mask)) begin
          status_ff <= 1'b1;
          change_ff <= 1'b1;
        end else if (status_ff && ((nxt_clr_hist & eff_mask) == eff_mask)) begin
          status_ff <= 1'b0;
          change_ff <= 1'b1;
        end
      end
    end
  end

  assign status = status_ff;
  assign change = change_ff;
endmodule : lpt_persist
`default_nettype wire

// [sim/lpt_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module lpt_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic [lpt_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [lpt_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lpt_pkg::DATA_W-1:0] reg_rdata,
  input wire logic adc_clk_tick,
  input wire logic vis_adc_tick,
  input wire logic ir_adc_tick,
  input wire logic [lpt_pkg::GAIN_W-1:0] visible_integration_gain,
  input wire logic visible_signal_range,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] ambient_hysteresis,
  input wire logic [lpt_pkg::SAMPLE_W-1:0] proximity_hysteresis,
  input wire logic amb_sample_valid,
  input wire logic amb_above_status,
  input wire logic [2:0] prox_sample_valid,
  input wire logic [2:0] prox_status
);
  import lpt_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_gain_rd;
    reg_rd && reg_addr == 8'h11;
  endsequence
  sequence s_amb_zero;
    reg_wr && reg_addr == 8'h16 && reg_wdata == 8'h00;
  endsequence
  gain_write_a: assert property (
    reg_wr && reg_addr == 8'h11 |=> visible_integration_gain == $past(reg_wdata[2:0]))
    else $error("gain write not taken");
  gain_read_a: assert property (
    s_gain_rd |=> reg_rdata == {5'h00, $past(visible_integration_gain)})
    else $error("gain read back wrong");
  range_write_a: assert property (
    reg_wr && reg_addr == 8'h12 |=> visible_signal_range == $past(reg_wdata[5]))
    else $error("range bit not taken");
  hyst_reset_a: assert property (
    $fell(reset) |-> ambient_hysteresis == 16'h0018 && proximity_hysteresis == 16'h0018)
    else $error("hysteresis reset value wrong");
  hyst_zero_a: assert property (
    s_amb_zero |-> ##[1:2] ambient_hysteresis == 16'h0000)
    else $error("zero hysteresis code not expanded");
  vis_tick_a: assert property (
    vis_adc_tick |-> $past(adc_clk_tick))
    else $error("visible tick without base tick");
  ir_tick_a: assert property (
    ir_adc_tick |-> $past(adc_clk_tick))
    else $error("infrared tick without base tick");
  amb_rise_a: assert property (
    $rose(amb_above_status) |-> $past(amb_sample_valid))
    else $error("ambient status rose without sample");
  prox_rise_a: assert property (
    $rose(prox_status[2]) |-> $past(prox_sample_valid[2]))
    else $error("proximity status rose without sample");
endmodule : lpt_monitor
`default_nettype wire

// [sim/lpt_host.sv]
`timescale 1ns/1ps
`default_nettype none
module lpt_host (
  input wire logic clk,
  input wire logic [7:0] reg_rdata,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Stale data is not left on the bus
    reg_wdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : lpt_host
`default_nettype wire

// [sim/light_prox_threshold_params_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module light_prox_threshold_params_bench;
  import lpt_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic reg_wr, reg_rd, vis_adc_tick, ir_adc_tick, ir_range_eff, visible_signal_range, irq, amb_above, amb_below;
  logic adc_clk_tick = 1'b0;
  logic av = 1'b0;
  logic ir_range_in = 1'b1;
  logic [2:0] ir_gain_in = 3'h2;
  logic [2:0] ir_rec_in = 3'h5;
  logic [2:0] vis_rec_in = 3'h3;
  logic [2:0] pv = 3'h0;
  logic [2:0] vgain, ir_gain_eff, ir_rec_eff, prox_status;
  logic [15:0] amb_hyst, prox_hyst;
  logic [15:0] amb_smp = 16'h0000;
  logic [15:0] amb_low = 16'd500;
  logic [15:0] ps [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] pth [3] = '{16'd100, 16'd200, 16'd300};
  int err_total = 0;
  int checks = 0;
  int vis_n = 0;
  int ir_n = 0;
  always #20 clk = ~clk;
  always @(negedge clk) begin
    vis_n += int'(vis_adc_tick);
    ir_n += int'(ir_adc_tick);
  end
  lpt_host u_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));
  lpt_top u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_clk_tick(adc_clk_tick), .vis_adc_tick(vis_adc_tick),
    .ir_adc_tick(ir_adc_tick), .ir_gain_in(ir_gain_in), .ir_range_in(ir_range_in), .ir_recovery_in(ir_rec_in),
    .vis_recovery_in(vis_rec_in), .visible_integration_gain(vgain), .visible_signal_range(visible_signal_range),
    .ir_gain_eff(ir_gain_eff), .ir_range_eff(ir_range_eff), .ir_recovery_eff(ir_rec_eff),
    .ambient_hysteresis(amb_hyst), .proximity_hysteresis(prox_hyst), .amb_sample_valid(av), .amb_sample(amb_smp),
    .ambient_lower_threshold(amb_low), .ambient_upper_threshold(16'd1000), .prox_sample_valid(pv),
    .prox1_sample(ps[0]), .prox2_sample(ps[1]), .prox3_sample(ps[2]), .proximity_threshold_one(pth[0]),
    .proximity_threshold_two(pth[1]), .proximity_threshold_three(pth[2]), .amb_above_status(amb_above),
    .amb_below_status(amb_below), .prox_status(prox_status), .irq(irq));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic samp(input int ch, input logic [15:0] v);
    @(posedge clk);
    if (ch == 3) begin
      av <= 1'b1;
      amb_smp <= v;
    end else begin
      pv[ch] <= 1'b1;
      ps[ch] <= v;
    end
    @(posedge clk);
    av <= 1'b0;
    pv <= 3'h0;
  endtask : samp
  task automatic test_reset();
    logic [7:0] adr [7] = '{8'h11, 8'h12, 8'h16, 8'h17, 8'h18, 8'h19, 8'h30};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h48, 8'h48, 8'h03, 8'h03, 8'h00};
    foreach (adr[i]) begin
      u_host.rd(adr[i], rd_val);
      chk("reset value", {8'h00, rd_val}, {8'h00, rv[i]});
    end
    chk("ambient hyst", amb_hyst, 16'd24);
    $display("test_reset done");
  endtask : test_reset
  task automatic test_gain();
    for (int g = 0; g < 8; g++) begin
      u_host.wr(8'h11, 8'hf8 | 8'(g));
      u_host.rd(8'h11, rd_val);
      chk("gain read", {8'h00, rd_val}, 16'(g));
      chk("gain out", {13'h0000, vgain}, 16'(g));
      vis_n = 0;
      ir_n = 0;
      @(posedge clk);
      adc_clk_tick <= 1'b1;
      repeat (4 << g) @(posedge clk);
      adc_clk_tick <= 1'b0;
      cyc(3);
      chk("vis ticks", 16'(vis_n), 16'd4);
      chk("ir ticks", 16'(ir_n), 16'(1 << g));
    end
    $display("test_gain done");
  endtask : test_gain
  task automatic test_range();
    u_host.wr(8'h12, 8'h20);
    u_host.rd(8'h12, rd_val);
    chk("misc read", {8'h00, rd_val}, 16'h0020);
    chk("range high", {15'h0000, visible_signal_range}, 16'h0001);
    u_host.wr(8'h12, 8'hdf);
    u_host.rd(8'h12, rd_val);
    chk("misc clear", {8'h00, rd_val}, 16'h0000);
    $display("test_range done");
  endtask : test_range
  task automatic test_legacy();
    u_host.wr(8'h20, 8'h01);
    cyc(3);
    chk("legacy gain", {13'h0000, ir_gain_eff}, 16'h0007);
    chk("legacy range", {15'h0000, ir_range_eff}, 16'h0000);
    chk("legacy rec", {13'h0000, ir_rec_eff}, 16'h0003);
    u_host.wr(8'h20, 8'h00);
    cyc(3);
    chk("own gain", {13'h0000, ir_gain_eff}, 16'h0002);
    chk("own range", {15'h0000, ir_range_eff}, 16'h0001);
    chk("own rec", {13'h0000, ir_rec_eff}, 16'h0005);
    $display("test_legacy done");
  endtask : test_legacy
  task automatic test_hyst();
    logic [7:0] code [3] = '{8'h00, 8'h5a, 8'h48};
    logic [15:0] exp [3] = '{16'd0, 16'd52, 16'd24};
    foreach (code[i]) begin
      u_host.wr(8'h16, code[i]);
      u_host.wr(8'h17, code[i]);
      cyc(2);
      chk("ambient hyst", amb_hyst, exp[i]);
      chk("prox hyst", prox_hyst, exp[i]);
    end
    $display("test_hyst done");
  endtask : test_hyst
  task automatic test_prox();
    u_host.wr(8'h22, 8'h00);
    u_host.wr(8'h18, 8'h07);
    for (int ch = 0; ch < 3; ch++) begin
      repeat (3) samp(ch, pth[ch] + 16'd24);
      cyc(2);
      chk("prox at hyst", {15'h0000, prox_status[ch]}, 16'h0000);
      repeat (2) samp(ch, pth[ch] + 16'd25);
      cyc(2);
      chk("prox two of three", {15'h0000, prox_status[ch]}, 16'h0000);
      samp(ch, pth[ch] + 16'd25);
      cyc(2);
      chk("prox set", {15'h0000, prox_status[ch]}, 16'h0001);
    end
    cyc(3);
    chk("irq masked", {15'h0000, irq}, 16'h0000);
    $display("test_prox done");
  endtask : test_prox
  task automatic test_amb();
    u_host.wr(8'h21, 8'h1f);
    u_host.wr(8'h22, 8'h01);
    u_host.wr(8'h19, 8'hff);
    repeat (7) samp(3, 16'd1100);
    samp(3, 16'd1010);
    repeat (7) samp(3, 16'd1100);
    cyc(2);
    chk("amb seven", {15'h0000, amb_above}, 16'h0000);
    samp(3, 16'd1100);
    cyc(2);
    chk("amb eight", {15'h0000, amb_above}, 16'h0001);
    cyc(3);
    chk("irq raised", {15'h0000, irq}, 16'h0001);
    u_host.rd(8'h21, rd_val);
    chk("irq status", {8'h00, rd_val}, 16'h0001);
    u_host.wr(8'h21, 8'h01);
    cyc(3);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    samp(3, 16'd476);
    repeat (7) samp(3, 16'd400);
    cyc(2);
    chk("amb below at hyst", {15'h0000, amb_below}, 16'h0000);
    chk("amb above cleared", {15'h0000, amb_above}, 16'h0000);
    samp(3, 16'd400);
    cyc(2);
    chk("amb below set", {15'h0000, amb_below}, 16'h0001);
    u_host.rd(8'h21, rd_val);
    chk("irq both", {8'h00, rd_val}, 16'h0003);
    u_host.rd(8'h23, rd_val);
    chk("thr status", {8'h00, rd_val}, 16'h001e);
    $display("test_amb done");
  endtask : test_amb
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    test_reset();
    test_gain();
    test_range();
    test_legacy();
    test_hyst();
    test_prox();
    test_amb();
    end_sim();
  end
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule : light_prox_threshold_params_bench
bind lpt_top lpt_monitor u_mon (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .adc_clk_tick,
  .vis_adc_tick, .ir_adc_tick, .visible_integration_gain, .visible_signal_range, .ambient_hysteresis,
  .proximity_hysteresis, .amb_sample_valid, .amb_above_status, .prox_sample_valid, .prox_status);
`default_nettype wire
